// ===== common/snsl_pkg.sv
// Shared constants and types for the serial-number and sleep command block
package snsl_pkg;

	// ==================================================================
	// Opcodes and serial-number store
	localparam logic [7:0]  OP_SN_PROGRAM = 8'hC2;
	localparam logic [7:0]  OP_SN_FETCH   = 8'hC3;
	localparam logic [7:0]  OP_DEEP_SLEEP = 8'hBA;
	localparam logic [7:0]  OP_HIBERNATE  = 8'hB9;
	localparam logic [7:0]  OP_PERMIT_DEF = 8'h06;
	localparam int          SN_BYTES      = 8;
	localparam logic [63:0] SN_RESET      = 64'h0000000000000000;

	// ==================================================================
	// Timing, system clock rate in MHz
	localparam int SYS_MHZ              = 250;
	localparam int DEEP_SLEEP_ENTRY_NS  = 3000;
	localparam int DEEP_SLEEP_EXIT_NS   = 10000;
	localparam int DEEP_SLEEP_PULSE_NS  = 100;
	localparam int HIBERNATE_ENTRY_NS   = 3000;
	localparam int HIBERNATE_EXIT_NS    = 450000;
	localparam int TMR_W                = 20;

	// Least times round up, longest times round down, never below one cycle
	function automatic int cyc_up(input int ns);
		int c;
		c = (ns * SYS_MHZ + 999) / 1000;
		return (c < 1) ? 1 : c;
	endfunction : cyc_up

	function automatic int cyc_dn(input int ns);
		int c;
		c = (ns * SYS_MHZ) / 1000;
		return (c < 1) ? 1 : c;
	endfunction : cyc_dn

	localparam int DS_ENTRY_CYC = cyc_up(DEEP_SLEEP_ENTRY_NS);
	localparam int DS_EXIT_CYC  = cyc_dn(DEEP_SLEEP_EXIT_NS);
	localparam int DS_PULSE_CYC = cyc_up(DEEP_SLEEP_PULSE_NS);
	localparam int HB_ENTRY_CYC = cyc_up(HIBERNATE_ENTRY_NS);
	localparam int HB_EXIT_CYC  = cyc_dn(HIBERNATE_EXIT_NS);

	// ==================================================================
	// Power states
	typedef enum logic [2:0] {
		PWR_ACTIVE,
		PWR_DS_ENTER,
		PWR_DS,
		PWR_DS_WAKE,
		PWR_HB_ENTER,
		PWR_HB,
		PWR_HB_WAKE
	} snsl_pwr_t;

endpackage : snsl_pkg

// ===== hw/snsl_top.sv
// Serial-number program/fetch and deep-sleep/hibernate command handling
`timescale 1ns/1ps

// Operation
// RULE1 - Eight-byte board serial number store, programmable only once.
// RULE2 - Host sends write-permit command in its own frame before programming.
// RULE3 - Program command takes following bytes as burst filling up to eight bytes.
// RULE4 - Programming completes only on the chip-select rising edge.
// RULE5 - Device computes no checksum; host appends CRC as lowest byte.
// RULE6 - Unprogrammed store reads all zero across sixty-four bits.
// RULE7 - Suggested layout: customer id, unique number, CRC; any format allowed.
// RULE8 - Fetch opcode after chip select falls returns serial bytes in a burst.
// RULE9 - Fetch burst wraps to first byte after the eighth.
// RULE10 - Fetch sends least significant byte first, most significant last.
// RULE11 - Deep sleep entered entry time after opcode and chip-select rise.
// RULE12 - In deep sleep ignore clock and input, output high impedance.
// RULE13 - Chip-select low pulse of wake width exits deep sleep after exit time.
// RULE14 - Host may wake with dummy frame or chip-select toggle alone.
// RULE15 - Outputs stay high impedance while waking from deep sleep.
// RULE16 - Hibernate entered entry time after opcode and chip-select rise.
// RULE17 - In hibernate ignore clock and input, output high impedance.
// RULE18 - First chip-select fall in hibernate wakes device within exit time.
// RULE19 - Output stays high impedance during hibernate wake-up.
// RULE20 - Host must not rely on opcodes sent during hibernate wake-up.
// RULE21 - Program command without preceding write-permit frame is ignored.
// RULE22 - No command executes while asleep or waking, until exit time ends.
module snsl_top
	import snsl_pkg::*;
#(
	parameter logic [7:0] WRITE_PERMIT_OP = OP_PERMIT_DEF,
	parameter int         HB_EXIT_CYCLES  = HB_EXIT_CYC
) (
	input  wire logic        clk_sys,
	input  wire logic        sys_rst,
	input  wire logic        spi_sck,
	input  wire logic        spi_cs_n,
	input  wire logic        spi_si,
	output logic             spi_so,
	output logic             spi_so_oe,
	output logic [63:0]      board_serial_number,
	output logic             sn_programmed,
	output logic             write_permit,
	output logic             deep_sleep_state,
	output logic             hibernate_state
);

	// ==================================================================
	// Elaboration checks
	if (HB_EXIT_CYCLES < 1 || HB_EXIT_CYCLES >= (1 << TMR_W)) begin : g_bad_hb_exit
		$error("HB_EXIT_CYCLES does not fit the wake timer");
	end

	// ==================================================================
	// Link domain (serial clock); frame state clears while chip select is high
	logic              sck_rst;
	logic [2:0]        bit_r;
	logic              opc_done_r;
	logic [6:0]        sh_r;
	logic [7:0]        opc_r;
	logic              seq_r;
	logic [63:0]       stage_r;
	logic [7:0]        wmask_r;
	logic [2:0]        widx_r;
	logic              rd_act_r;
	logic [2:0]        tx_bit_r;
	logic [2:0]        tx_idx_r;
	logic              so_r;
	logic [1:0]        awake_s_r;
	logic [7:0]        byte_in;
	logic              link_on;
	logic              awake_r;
	logic [63:0]       sn_r;

	assign sck_rst = sys_rst | spi_cs_n;
	assign byte_in = {sh_r, spi_si};
	assign link_on = awake_s_r[1];

	// Awake level into the link domain; resets awake like its source, else first frame is lost
	always_ff @(posedge spi_sck or posedge sys_rst) begin
		if (sys_rst) begin
			awake_s_r <= 2'h3;
		end else begin
			awake_s_r <= {awake_s_r[0], awake_r};
		end
	end

	// Bit framing
	always_ff @(posedge spi_sck or posedge sck_rst) begin
		if (sck_rst) begin
			bit_r      <= 3'h0;
			opc_done_r <= 1'b0;
			sh_r       <= 7'h00;
			widx_r     <= 3'h0;
			rd_act_r   <= 1'b0;
		end else if (link_on) begin // [RULE12] [RULE17]
			bit_r <= bit_r + 3'h1;
			sh_r  <= byte_in[6:0];
			if (bit_r == 3'h7 && !opc_done_r) begin
				opc_done_r <= 1'b1;
				rd_act_r   <= (byte_in == OP_SN_FETCH); // [RULE8]
			end else if (bit_r == 3'h7 && opc_r == OP_SN_PROGRAM) begin
				widx_r <= widx_r + 3'h1;
			end
		end
	end

	// Opcode and write staging outlive the frame; the system side reads them after it
	always_ff @(posedge spi_sck or posedge sys_rst) begin
		if (sys_rst) begin
			opc_r   <= 8'h00;
			seq_r   <= 1'b0;
			stage_r <= 64'h0000000000000000;
			wmask_r <= 8'h00;
		end else if (link_on && !spi_cs_n) begin
			if (bit_r == 3'h0 && !opc_done_r) begin
				wmask_r <= 8'h00;
			end
			if (bit_r == 3'h7 && !opc_done_r) begin
				opc_r <= byte_in;
				seq_r <= ~seq_r;
			end else if (bit_r == 3'h7 && opc_r == OP_SN_PROGRAM) begin
				stage_r[widx_r*8 +: 8] <= byte_in; // [RULE3]
				wmask_r[widx_r]        <= 1'b1;
			end
		end
	end

	// Fetch data out on falling edges, low byte first, msb first within a byte
	always_ff @(negedge spi_sck or posedge sck_rst) begin
		if (sck_rst) begin
			tx_bit_r <= 3'h0;
			tx_idx_r <= 3'h0;
			so_r     <= 1'b0;
		end else if (rd_act_r) begin
			so_r     <= sn_r[tx_idx_r*8 + (7 - tx_bit_r)]; // [RULE10]
			tx_bit_r <= tx_bit_r + 3'h1;
			if (tx_bit_r == 3'h7) begin
				tx_idx_r <= tx_idx_r + 3'h1; // [RULE9]
			end
		end
	end

	assign spi_so    = so_r;
	assign spi_so_oe = rd_act_r & link_on & ~spi_cs_n; // [RULE12] [RULE15] [RULE17] [RULE19]

	// ==================================================================
	// System domain: synchronisers, three stages, change once stages 2 and 3 agree
	logic [2:0]        cs_m_r;
	logic              cs_f_r;
	logic              cs_prev_r;
	logic [2:0]        seq_m_r;
	logic              seq_f_r;
	logic              seq_seen_r;
	logic              cs_rise;
	logic              cs_fall;

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			cs_m_r    <= 3'h7;
			cs_f_r    <= 1'b1;
			cs_prev_r <= 1'b1;
		end else begin
			cs_m_r    <= {cs_m_r[1:0], spi_cs_n};
			cs_prev_r <= cs_f_r;
			if (cs_m_r[1] == cs_m_r[2]) begin
				cs_f_r <= cs_m_r[2];
			end
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			seq_m_r <= 3'h0;
			seq_f_r <= 1'b0;
		end else begin
			seq_m_r <= {seq_m_r[1:0], seq_r};
			if (seq_m_r[1] == seq_m_r[2]) begin
				seq_f_r <= seq_m_r[2];
			end
		end
	end

	assign cs_rise = cs_f_r & ~cs_prev_r;
	assign cs_fall = ~cs_f_r & cs_prev_r;

	// ==================================================================
	// Command execution at frame end
	snsl_pwr_t         st_r;
	snsl_pwr_t         st_nxt;
	logic [TMR_W-1:0]  tmr_r;
	logic [TMR_W-1:0]  tmr_nxt;
	logic [TMR_W-1:0]  pulse_r;
	logic              frame_ok_r;
	logic              sn_prog_r;
	logic              permit_r;
	logic              exec;

	// A frame counts only if it began awake and completed an opcode
	assign exec = cs_rise & frame_ok_r & (seq_f_r != seq_seen_r) & (st_r == PWR_ACTIVE); // [RULE4] [RULE22]

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			frame_ok_r <= 1'b0;
			seq_seen_r <= 1'b0;
		end else begin
			if (cs_fall) begin
				frame_ok_r <= (st_r == PWR_ACTIVE); // [RULE20] [RULE22]
			end
			if (cs_rise) begin
				seq_seen_r <= seq_f_r;
			end
		end
	end

	// Write permit, consumed by any program frame
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			permit_r <= 1'b0;
		end else if (exec && opc_r == WRITE_PERMIT_OP) begin
			permit_r <= 1'b1; // [RULE2]
		end else if (exec && opc_r == OP_SN_PROGRAM) begin
			permit_r <= 1'b0;
		end
	end

	// One-time store; checksum is left entirely to the host
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			sn_r      <= SN_RESET; // [RULE6]
			sn_prog_r <= 1'b0;
		end else if (exec && opc_r == OP_SN_PROGRAM && permit_r && !sn_prog_r) begin // [RULE21]
			for (int i = 0; i < SN_BYTES; i++) begin
				if (wmask_r[i]) begin
					sn_r[i*8 +: 8] <= stage_r[i*8 +: 8]; // [RULE1] [RULE5] [RULE7]
				end
			end
			sn_prog_r <= |wmask_r; // [RULE1]
		end
	end

	// ==================================================================
	// Power state machine
	always_comb begin
		st_nxt  = st_r;
		tmr_nxt = (tmr_r == '0) ? '0 : tmr_r - 1'b1;
		case (st_r)
			PWR_ACTIVE: begin
				if (exec && opc_r == OP_DEEP_SLEEP) begin
					st_nxt  = PWR_DS_ENTER; // [RULE11]
					tmr_nxt = TMR_W'(DS_ENTRY_CYC - 1);
				end else if (exec && opc_r == OP_HIBERNATE) begin
					st_nxt  = PWR_HB_ENTER; // [RULE16]
					tmr_nxt = TMR_W'(HB_ENTRY_CYC - 1);
				end
			end
			PWR_DS_ENTER: begin
				if (tmr_r == '0) begin
					st_nxt = PWR_DS;
				end
			end
			PWR_DS: begin
				if (!cs_f_r && pulse_r == TMR_W'(DS_PULSE_CYC - 1)) begin
					st_nxt  = PWR_DS_WAKE; // [RULE13] [RULE14]
					tmr_nxt = TMR_W'(DS_EXIT_CYC - 1);
				end
			end
			PWR_HB_ENTER: begin
				if (tmr_r == '0) begin
					st_nxt = PWR_HB;
				end
			end
			PWR_HB: begin
				if (cs_fall) begin
					st_nxt  = PWR_HB_WAKE; // [RULE18]
					tmr_nxt = TMR_W'(HB_EXIT_CYCLES - 1);
				end
			end
			PWR_DS_WAKE,
			PWR_HB_WAKE: begin
				if (tmr_r == '0) begin
					st_nxt = PWR_ACTIVE; // [RULE22]
				end
			end
			default: begin
				st_nxt = PWR_ACTIVE;
			end
		endcase
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			st_r  <= PWR_ACTIVE;
			tmr_r <= '0;
		end else begin
			st_r  <= st_nxt;
			tmr_r <= tmr_nxt;
		end
	end

	// Chip-select low width in deep sleep; counts the filtered level, so both edges lag alike
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			pulse_r <= '0;
		end else if (st_r != PWR_DS || cs_f_r) begin
			pulse_r <= '0;
		end else if (pulse_r != TMR_W'(DS_PULSE_CYC - 1)) begin
			pulse_r <= pulse_r + 1'b1; // [RULE13]
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			awake_r <= 1'b1;
		end else begin
			awake_r <= (st_nxt == PWR_ACTIVE); // [RULE12] [RULE17]
		end
	end

	assign board_serial_number = sn_r;
	assign sn_programmed       = sn_prog_r;
	assign write_permit        = permit_r;
	assign deep_sleep_state    = (st_r == PWR_DS);
	assign hibernate_state     = (st_r == PWR_HB);

	// ==================================================================
	// Assertions
	AST_SN_ONCE: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE1]
		$past(sn_prog_r) |-> (sn_r == $past(sn_r)))
		else $error("serial number changed after programming");

	AST_SN_ZERO: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE6]
		!sn_prog_r |-> (sn_r == 64'h0000000000000000))
		else $error("unprogrammed serial number not zero");

	AST_SN_NEEDS_PERMIT: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE21]
		(sn_r != $past(sn_r)) |-> ($past(permit_r) && !permit_r))
		else $error("serial number written without permit");

	AST_DS_ENTRY: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE11]
		(st_r == PWR_ACTIVE && st_nxt == PWR_DS_ENTER)
		|=> (st_r == PWR_DS_ENTER)[*8] ##0 (tmr_r == TMR_W'(DS_ENTRY_CYC - 8)))
		else $error("deep sleep entry timing wrong");

	AST_DS_PULSE: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE13]
		(st_r == PWR_DS && st_nxt == PWR_DS_WAKE) |-> !cs_f_r && $past(!cs_f_r)
		##1 (st_r == PWR_DS_WAKE && tmr_r == TMR_W'(DS_EXIT_CYC - 1)))
		else $error("deep sleep wake without full pulse");

	AST_HB_WAKE: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE18]
		(st_r == PWR_HB && cs_fall) |=> (st_r == PWR_HB_WAKE) ##0 (tmr_r != '0 || st_nxt == PWR_ACTIVE))
		else $error("hibernate did not start waking on chip select fall");

	AST_WAKE_DONE: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE22]
		(st_r inside {PWR_DS_WAKE, PWR_HB_WAKE} && tmr_r == '0) |=> (st_r == PWR_ACTIVE) && awake_r)
		else $error("wake did not return to active");

	AST_ASLEEP_NO_CMD: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE22]
		(st_r != PWR_ACTIVE && $past(st_r != PWR_ACTIVE)) |-> $stable(permit_r) && $stable(sn_r))
		else $error("command executed while asleep");

	AST_FETCH_WRAP: assert property (@(negedge spi_sck) disable iff (sck_rst) // [RULE9]
		(rd_act_r && tx_bit_r == 3'h7 && tx_idx_r == 3'h7) |=> (tx_idx_r == 3'h0 && tx_bit_r == 3'h0))
		else $error("fetch burst did not wrap to byte 0");

	AST_SO_QUIET: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE12]
		(st_r inside {PWR_DS, PWR_HB} && $past(st_r, 4) inside {PWR_DS, PWR_HB}) |-> !spi_so_oe)
		else $error("serial output driven while asleep");

endmodule : snsl_top

// ===== tb/snsl_spi_host.sv
// Bus controller model: mode 0 frames, serial clock only within frames
`timescale 1ns/1ps
module snsl_spi_host (
	output logic       spi_sck,
	output logic       spi_cs_n,
	output logic       spi_si,
	input  wire logic  so_line,
	input  wire logic  spi_so_oe
);
	initial begin
		spi_sck  = 1'b0;
		spi_cs_n = 1'b1;
		spi_si   = 1'b0;
	end

	// ========================================
	// Frame end and chip-select only pulse
	task automatic release_cs;
		#8 spi_cs_n = 1'b1;
		// Data line no longer meaningful, so it shows the inverse
		spi_si = ~spi_si;
		#30;
	endtask : release_cs

	task automatic cs_pulse(input int ns);
		#1.3 spi_cs_n = 1'b0;
		#(ns) spi_cs_n = 1'b1;
		#30;
	endtask : cs_pulse

	// ========================================
	// One frame, opcode first after chip select falls
	task automatic frame(input logic [7:0] txq[$], input logic hold,
			output logic [7:0] rxq[$], output logic oe_seen);
		logic [7:0] b;
		rxq = {};
		oe_seen = 1'b0;
		// Off the system clock edge, phase unrelated
		#1.3 spi_cs_n = 1'b0;
		#3;
		foreach (txq[i]) begin
			for (int k = 7; k >= 0; k--) begin
				spi_si = txq[i][k];
				#3 spi_sck = 1'b1;
				// Sampled a little after the edge to dodge the output enable race
				#1 b[k] = so_line;
				oe_seen |= spi_so_oe;
				#2 spi_sck = 1'b0;
			end
			rxq.push_back(b);
		end
		if (!hold) begin
			release_cs();
		end
	endtask : frame
endmodule : snsl_spi_host

// ===== tb/snsl_top_bench.sv
// Self-checking bench for the serial-number and sleep command block
`timescale 1ns/1ps
module snsl_top_bench
	import snsl_pkg::*;
;
	localparam int          HB_EXIT = 40;
	// Low byte plays the host-computed check byte
	localparam logic [63:0] SN_VAL  = 64'h12A5_3C96_0F1E_2DB4;

	typedef struct {
		int         pos;
		logic [7:0] exp;
	} snsl_row_t;

	logic        clk_sys;
	logic        sys_rst;
	wire         spi_sck;
	wire         spi_cs_n;
	wire         spi_si;
	logic        spi_so;
	logic        spi_so_oe;
	logic [63:0] board_serial_number;
	logic        sn_programmed;
	logic        write_permit;
	logic        deep_sleep_state;
	logic        hibernate_state;
	wire         so_line = spi_so_oe ? spi_so : 1'bz;
	int          fail_count;
	int          checks_done;
	logic [7:0]  rx[$];
	logic        oe;
	snsl_row_t   rows[10];

	snsl_top #(.HB_EXIT_CYCLES(HB_EXIT)) snsl_top_i (
		.clk_sys             (clk_sys),
		.sys_rst             (sys_rst),
		.spi_sck             (spi_sck),
		.spi_cs_n            (spi_cs_n),
		.spi_si              (spi_si),
		.spi_so              (spi_so),
		.spi_so_oe           (spi_so_oe),
		.board_serial_number (board_serial_number),
		.sn_programmed       (sn_programmed),
		.write_permit        (write_permit),
		.deep_sleep_state    (deep_sleep_state),
		.hibernate_state     (hibernate_state)
	);

	snsl_spi_host snsl_spi_host_i (
		.spi_sck   (spi_sck),
		.spi_cs_n  (spi_cs_n),
		.spi_si    (spi_si),
		.so_line   (so_line),
		.spi_so_oe (spi_so_oe)
	);

	always #2 clk_sys = ~clk_sys;

	// ========================================
	// Helpers
	task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %0t %s: seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : tally_and_finish

	task automatic cycles(input int n);
		repeat (n) @(posedge clk_sys);
		// Look once the edge's updates have settled
		#1;
	endtask : cycles

	task automatic send(input logic [7:0] q[$], input logic hold = 1'b0);
		snsl_spi_host_i.frame(q, hold, rx, oe);
	endtask : send

	task automatic fetch(input int n);
		logic [7:0] q[$];
		q = {OP_SN_FETCH};
		repeat (n) q.push_back(8'h00);
		send(q);
	endtask : fetch

	task automatic write_sn(input logic [63:0] v, input logic hold);
		logic [7:0] q[$];
		q = {OP_SN_PROGRAM};
		for (int i = 0; i < 8; i++) q.push_back(v[8*i +: 8]);
		send(q, hold);
	endtask : write_sn

	// ========================================
	// Watchdog, several times the expected run
	initial begin
		#100000;
		fail_count++;
		$display("BAD %0t watchdog expired", $time);
		tally_and_finish();
	end

	// ========================================
	// Main sequence
	initial begin
		clk_sys = 1'b0;
		sys_rst = 1'b1;
		fail_count = 0;
		checks_done = 0;
		for (int k = 0; k < 10; k++) rows[k] = '{k, SN_VAL[8*(k%8) +: 8]};
		repeat (4) @(posedge clk_sys);
		sys_rst <= 1'b0;
		cycles(4);
		check(board_serial_number, SN_RESET, "reset store");
		check({sn_programmed, write_permit, deep_sleep_state, hibernate_state, spi_so_oe},
			64'h0, "reset flags");
		fetch(9);
		check(oe, 1'b1, "fetch drives");
		for (int i = 1; i < 10; i++) check(rx[i], 8'h00, "blank fetch");
		write_sn(SN_VAL, 1'b0);
		cycles(10);
		check(board_serial_number, SN_RESET, "program without permit");
		send({OP_PERMIT_DEF});
		cycles(10);
		check(write_permit, 1'b1, "permit set");
		write_sn(SN_VAL, 1'b1);
		cycles(20);
		check(board_serial_number, SN_RESET, "store before frame end");
		snsl_spi_host_i.release_cs();
		cycles(10);
		check(board_serial_number, SN_VAL, "store programmed");
		check({sn_programmed, write_permit}, 64'h2, "flags after program");
		send({OP_PERMIT_DEF});
		write_sn(~SN_VAL, 1'b0);
		cycles(10);
		check(board_serial_number, SN_VAL, "second program");
		fetch(10);
		foreach (rows[r]) check(rx[rows[r].pos + 1], rows[r].exp, "fetch byte");
		// Deep sleep entry, short frame inside, then chip-select wake
		send({OP_DEEP_SLEEP});
		cycles(600);
		check(deep_sleep_state, 1'b0, "deep sleep early");
		cycles(200);
		check(deep_sleep_state, 1'b1, "deep sleep entered");
		fetch(0);
		check(oe, 1'b0, "asleep output");
		check(deep_sleep_state, 1'b1, "short pulse keeps sleep");
		snsl_spi_host_i.cs_pulse(120);
		cycles(5);
		check(deep_sleep_state, 1'b0, "wake pulse");
		cycles(2000);
		fetch(2);
		check(oe, 1'b0, "waking from deep sleep");
		cycles(700);
		send({8'h00});
		fetch(1);
		check({oe, rx[1]}, {1'b1, SN_VAL[7:0]}, "awake after deep sleep");
		// Hibernate entry and wake by the next frame
		send({OP_HIBERNATE});
		cycles(800);
		check(hibernate_state, 1'b1, "hibernate entered");
		fetch(1);
		check(oe, 1'b0, "waking from hibernate");
		check(hibernate_state, 1'b0, "hibernate left");
		cycles(HB_EXIT + 20);
		send({8'h00});
		fetch(1);
		check({oe, rx[1]}, {1'b1, SN_VAL[7:0]}, "awake after hibernate");
		// Mid-run reset: blank store, first frame after release needs no dummy byte
		@(posedge clk_sys);
		sys_rst <= 1'b1;
		repeat (4) @(posedge clk_sys);
		sys_rst <= 1'b0;
		cycles(4);
		check(board_serial_number, SN_RESET, "store after mid-run reset");
		fetch(1);
		check({oe, rx[1]}, {1'b1, 8'h00}, "fetch after mid-run reset");
		tally_and_finish();
	end
endmodule : snsl_top_bench
